/* rtl/gpio_pin_pair_control.sv */
// How it works
// - Stored clock value drives pin when output
// - Clock value written only with mask set
// - Clock value mask not stored, reads zero
// - Pin shows only accepted value when output
// - Clock value resets to one
// - Clock direction bit is pin output enable
// - Clock direction written only with mask
// - Direction zero input tri-stated, one output
// - Direction mask selects update or not
// - Direction mask not stored, reads zero
// - Six 32-bit registers from base address
// - Each register resets to 0x00000808
// - Data half mirrors the clock half
// - Read-only bits report sampled pin levels
module gpio_pin_pair_control (
    input wire logic clk,
    input wire logic rst,
    input wire logic [19:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    input wire logic [5:0] clkPinIn,
    output logic [5:0] clkPinOut,
    output logic [5:0] clkPinOe,
    input wire logic [5:0] datPinIn,
    output logic [5:0] datPinOut,
    output logic [5:0] datPinOe
);

    // ****************************************************
    // Address decode
    // ****************************************************

    // Word index of an address, or PAIR_COUNT when unmapped
    function automatic logic [2:0] pairIndex(input logic [19:0] addr);
        logic [19:0] offs;
        offs = addr - pin_pair_pkg::CTL_BASE_ADDR;
        if (addr < pin_pair_pkg::CTL_BASE_ADDR ||
            addr > pin_pair_pkg::CTL_LAST_ADDR || offs[1:0] != 2'b00) begin
            return 3'(pin_pair_pkg::PAIR_COUNT);
        end
        return offs[4:2];
    endfunction

    logic [2:0] accIdx;
    assign accIdx = pairIndex(regAddr);

    pin_pair_pkg::pair_state_type pair_q [pin_pair_pkg::PAIR_COUNT];
    logic [5:0] clkSync;
    logic [5:0] datSync;

    // ****************************************************
    // Per pair storage and pins
    // ****************************************************
    genvar g;
    generate
        for (g = 0; g < pin_pair_pkg::PAIR_COUNT; g++) begin : gPair
            logic hit;
            assign hit = regWrite && (accIdx == 3'(g));

            // Masked update; mask bits themselves never stored
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pair_q[g].clkVal <= pin_pair_pkg::CLK_VAL_RESET;
                    pair_q[g].clkDir <= pin_pair_pkg::DIR_RESET;
                    pair_q[g].datVal <= pin_pair_pkg::DAT_VAL_RESET;
                    pair_q[g].datDir <= pin_pair_pkg::DIR_RESET;
                end else if (hit) begin
                    if (regWdata[pin_pair_pkg::CLK_VAL_MASK_BIT]) begin
                        pair_q[g].clkVal <=
                            regWdata[pin_pair_pkg::CLK_VAL_BIT];
                    end
                    if (regWdata[pin_pair_pkg::CLK_DIR_MASK_BIT]) begin
                        pair_q[g].clkDir <=
                            regWdata[pin_pair_pkg::CLK_DIR_BIT];
                    end
                    if (regWdata[pin_pair_pkg::DAT_VAL_MASK_BIT]) begin
                        pair_q[g].datVal <=
                            regWdata[pin_pair_pkg::DAT_VAL_BIT];
                    end
                    if (regWdata[pin_pair_pkg::DAT_DIR_MASK_BIT]) begin
                        pair_q[g].datDir <=
                            regWdata[pin_pair_pkg::DAT_DIR_BIT];
                    end
                end
            end

            // Pads see only stored bits, so rejected writes never leak
            assign clkPinOut[g] = pair_q[g].clkVal;
            assign clkPinOe[g] = pair_q[g].clkDir;
            assign datPinOut[g] = pair_q[g].datVal;
            assign datPinOe[g] = pair_q[g].datDir;

            // Pad levels are asynchronous to clk
            pin_sync uClkSync (
                .clk(clk),
                .rst(rst),
                .pinIn(clkPinIn[g]),
                .pinSync(clkSync[g])
            );
            pin_sync uDatSync (
                .clk(clk),
                .rst(rst),
                .pinIn(datPinIn[g]),
                .pinSync(datSync[g])
            );
        end
    endgenerate

    // ****************************************************
    // Read path
    // ****************************************************
    logic [31:0] rdWord;

    // Mask and reserved bits read zero; unmapped reads zero
    always_comb begin
        rdWord = 32'h00000000;
        if (accIdx < 3'(pin_pair_pkg::PAIR_COUNT)) begin
            rdWord[pin_pair_pkg::CLK_VAL_BIT] = pair_q[accIdx].clkVal;
            rdWord[pin_pair_pkg::CLK_DIR_BIT] = pair_q[accIdx].clkDir;
            rdWord[pin_pair_pkg::DAT_VAL_BIT] = pair_q[accIdx].datVal;
            rdWord[pin_pair_pkg::DAT_DIR_BIT] = pair_q[accIdx].datDir;
            rdWord[pin_pair_pkg::CLK_IN_BIT] = clkSync[accIdx];
            rdWord[pin_pair_pkg::DAT_IN_BIT] = datSync[accIdx];
        end
    end

    // Read data registered: one cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h00000000;
        end else if (regRead) begin
            regRdata <= rdWord;
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    sequence clkValWrite(int idx);
        regWrite && accIdx == 3'(idx) &&
            regWdata[pin_pair_pkg::CLK_VAL_MASK_BIT];
    endsequence

    mask_reads_zero_a: assert property (
        @(posedge clk) disable iff (rst)
        regRead |=> (regRdata[pin_pair_pkg::CLK_VAL_MASK_BIT] == 1'b0 &&
            regRdata[pin_pair_pkg::DAT_VAL_MASK_BIT] == 1'b0))
        else $error("value mask bit read back nonzero");

    dir_mask_zero_a: assert property (
        @(posedge clk) disable iff (rst)
        regRead |=> (regRdata[pin_pair_pkg::CLK_DIR_MASK_BIT] == 1'b0 &&
            regRdata[pin_pair_pkg::DAT_DIR_MASK_BIT] == 1'b0))
        else $error("direction mask bit read back nonzero");

    clk_val_take_a: assert property (
        @(posedge clk) disable iff (rst)
        clkValWrite(0) |=>
            clkPinOut[0] == $past(regWdata[pin_pair_pkg::CLK_VAL_BIT]))
        else $error("masked clock value not accepted");

    clk_val_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        (regWrite && accIdx == 3'd0 &&
            !regWdata[pin_pair_pkg::CLK_VAL_MASK_BIT]) |=> $stable(clkPinOut[0]))
        else $error("clock value changed without mask");

    clk_dir_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        (regWrite && accIdx == 3'd0 &&
            !regWdata[pin_pair_pkg::CLK_DIR_MASK_BIT]) |=> $stable(clkPinOe[0]))
        else $error("clock direction changed without mask");

    clk_dir_take_a: assert property (
        @(posedge clk) disable iff (rst)
        (regWrite && accIdx == 3'd1 && regWdata[pin_pair_pkg::CLK_DIR_MASK_BIT])
            |=> clkPinOe[1] == $past(regWdata[pin_pair_pkg::CLK_DIR_BIT]))
        else $error("masked clock direction not accepted");

    out_reads_back_a: assert property (
        @(posedge clk) disable iff (rst)
        (regRead && accIdx == 3'd2) |=>
            (regRdata[pin_pair_pkg::CLK_VAL_BIT] == $past(clkPinOut[2]) &&
            regRdata[pin_pair_pkg::CLK_DIR_BIT] == $past(clkPinOe[2])))
        else $error("read word disagrees with pin drive");

    unmapped_zero_a: assert property (
        @(posedge clk) disable iff (rst)
        (regRead && accIdx == 3'(pin_pair_pkg::PAIR_COUNT)) |=> regRdata == 0)
        else $error("unmapped read returned data");

    sync_delay_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(clkSync[3]) |-> $past(clkPinIn[3], 2))
        else $error("clock input not delayed two cycles");

    dat_val_take_a: assert property (
        @(posedge clk) disable iff (rst)
        (regWrite && accIdx == 3'd4 && regWdata[pin_pair_pkg::DAT_VAL_MASK_BIT])
            |=> datPinOut[4] == $past(regWdata[pin_pair_pkg::DAT_VAL_BIT]))
        else $error("masked data value not accepted");

    // ****************************************************
    // Checks on the data half, the far pairs, the inputs, and pad and read data holding
    // ****************************************************

    // Write to one pair that carries a given mask bit
    sequence maskedWrite(int idx, int bitPos);
        regWrite && accIdx == 3'(idx) && regWdata[bitPos];
    endsequence

    // Write to one pair with a given mask bit clear
    sequence unmaskedWrite(int idx, int bitPos);
        regWrite && accIdx == 3'(idx) && !regWdata[bitPos];
    endsequence

    // Last pair decodes like the first
    clk_val_far_a: assert property (
        @(posedge clk) disable iff (rst)
        maskedWrite(5, pin_pair_pkg::CLK_VAL_MASK_BIT) |=>
            clkPinOut[5] == $past(regWdata[pin_pair_pkg::CLK_VAL_BIT]))
        else $error("far pair clock value not accepted");

    // Data value keeps its content without its mask
    dat_val_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        unmaskedWrite(4, pin_pair_pkg::DAT_VAL_MASK_BIT) |=>
            $stable(datPinOut[4]))
        else $error("data value changed without mask");

    // Data direction follows a masked write
    dat_dir_take_a: assert property (
        @(posedge clk) disable iff (rst)
        maskedWrite(5, pin_pair_pkg::DAT_DIR_MASK_BIT) |=>
            datPinOe[5] == $past(regWdata[pin_pair_pkg::DAT_DIR_BIT]))
        else $error("masked data direction not accepted");

    // Data direction keeps its content without its mask
    dat_dir_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        unmaskedWrite(5, pin_pair_pkg::DAT_DIR_MASK_BIT) |=>
            $stable(datPinOe[5]))
        else $error("data direction changed without mask");

    // Clock pads move only on a write cycle
    no_write_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        !regWrite |=> ($stable(clkPinOut) && $stable(clkPinOe)))
        else $error("clock pads moved without a write");

    // Read data stands until the next read
    rdata_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        !regRead |=> $stable(regRdata))
        else $error("read data changed without a read");

    // Data input also waits two stages
    dat_sync_delay_a: assert property (
        @(posedge clk) disable iff (rst)
        $fell(datSync[3]) |-> !$past(datPinIn[3], 2))
        else $error("data input not delayed two cycles");

    // Falling clock input waits two stages as well
    clk_fall_sync_a: assert property (
        @(posedge clk) disable iff (rst)
        $fell(clkSync[0]) |-> !$past(clkPinIn[0], 2))
        else $error("falling clock input not delayed");

    // Input bits report the synchronised levels
    in_bit_read_a: assert property (
        @(posedge clk) disable iff (rst)
        (regRead && accIdx == 3'd3) |=>
            (regRdata[pin_pair_pkg::CLK_IN_BIT] == $past(clkSync[3]) &&
            regRdata[pin_pair_pkg::DAT_IN_BIT] == $past(datSync[3])))
        else $error("input bits disagree with synchroniser");

    // Data half reads back what drives the pad
    dat_reads_back_a: assert property (
        @(posedge clk) disable iff (rst)
        (regRead && accIdx == 3'd0) |=>
            (regRdata[pin_pair_pkg::DAT_VAL_BIT] == $past(datPinOut[0]) &&
            regRdata[pin_pair_pkg::DAT_DIR_BIT] == $past(datPinOe[0])))
        else $error("data read word disagrees with pad");

endmodule

/* rtl/pin_pair_pkg.sv */
package pin_pair_pkg;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam int PAIR_COUNT = 6;
    localparam logic [19:0] CTL_BASE_ADDR = 20'hC5010;
    localparam logic [19:0] CTL_LAST_ADDR = 20'hC5027;
    localparam logic [31:0] CTL_RESET = 32'h00000808;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int CLK_DIR_MASK_BIT = 0;
    localparam int CLK_DIR_BIT = 1;
    localparam int CLK_VAL_MASK_BIT = 2;
    localparam int CLK_VAL_BIT = 3;
    localparam int CLK_IN_BIT = 4;
    localparam int DAT_DIR_MASK_BIT = 8;
    localparam int DAT_DIR_BIT = 9;
    localparam int DAT_VAL_MASK_BIT = 10;
    localparam int DAT_VAL_BIT = 11;
    localparam int DAT_IN_BIT = 12;

    // Reset state of the stored bits
    localparam logic CLK_VAL_RESET = 1'b1;
    localparam logic DAT_VAL_RESET = 1'b1;
    localparam logic DIR_RESET = 1'b0;

    // One line of a pin pair as seen at the pads
    typedef struct packed {
        logic outVal;
        logic outEn;
    } line_drive_type;

    // Stored state of one pair
    typedef struct packed {
        logic clkVal;
        logic clkDir;
        logic datVal;
        logic datDir;
    } pair_state_type;

endpackage

/* rtl/pin_sync.sv */
module pin_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pinIn,
    output logic pinSync
);

    logic meta_q;

    // Two flops; the first is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            pinSync <= 1'b0;
        end else begin
            meta_q <= pinIn;
            pinSync <= meta_q;
        end
    end

endmodule

/* tb/pin_pair_bus_model.sv */
// ****************************************************
// Open-drain pull-up lines of the attached devices
// ****************************************************
module pin_pair_bus_model (
    input wire logic [5:0] clkPinOut,
    input wire logic [5:0] clkPinOe,
    input wire logic [5:0] datPinOut,
    input wire logic [5:0] datPinOe,
    input wire logic [5:0] holdClk,
    input wire logic [5:0] holdDat,
    output logic [5:0] clkLine,
    output logic [5:0] datLine
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up wins unless someone pulls low; tri-stated pad reads high
    assign clkLine = ~((clkPinOe & ~clkPinOut) | holdClk);
    assign datLine = ~((datPinOe & ~datPinOut) | holdDat);
endmodule

/* tb/tb_gpio_pin_pair_control.sv */
module tb_gpio_pin_pair_control;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************
    // Signals and instances
    // ****************************************************
    logic clk, rst, regWrite, regRead;
    logic [19:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic [5:0] clkPinOut, clkPinOe, datPinOut, datPinOe;
    logic [5:0] clkLine, datLine, holdClk, holdDat;
    logic [19:0] base;
    int errorCnt, cmpCount;
    assign base = pin_pair_pkg::CTL_BASE_ADDR;
    gpio_pin_pair_control dut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .clkPinIn(clkLine), .clkPinOut(clkPinOut),
        .clkPinOe(clkPinOe), .datPinIn(datLine), .datPinOut(datPinOut),
        .datPinOe(datPinOe));
    pin_pair_bus_model bus (.clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
        .datPinOut(datPinOut), .datPinOe(datPinOe), .holdClk(holdClk),
        .holdDat(holdDat), .clkLine(clkLine), .datLine(datLine));
    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobe lowered then one idle edge, so calls can follow directly
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge clk) #1;
        regWrite = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] e);
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk) #1;
        regRead = 1'b0;
        chk(regRdata, e);
        @(posedge clk) #1;
    endtask
    task automatic pins(input logic [5:0] oe, input logic [5:0] o);
        chk(32'(clkPinOe), 32'(oe));
        chk(32'(clkPinOut), 32'(o));
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic tReset();
        pins(6'h00, 6'h3F);
        repeat (2) @(posedge clk) #1;
        for (int i = 0; i < 6; i++) begin
            rd(base + 20'(4 * i), 32'h00001818);
        end
        $display("reset test done");
    endtask
    task automatic tMask();
        wr(base, 32'h0000000F);
        pins(6'h01, 6'h3F);
        wr(base, 32'h00000000);
        pins(6'h01, 6'h3F);
        rd(base, 32'h0000181A);
        wr(base, 32'h00000005);
        pins(6'h00, 6'h3E);
        rd(base, 32'h00001810);
        wr(base, 32'h00000006);
        chk(32'(clkPinOe), 32'h0);
        wr(base, 32'h00000003);
        pins(6'h01, 6'h3E);
        repeat (2) @(posedge clk) #1;
        rd(base, 32'h00001802);
        $display("mask test done");
    endtask
    // Input level reaches the read path only after two stages
    task automatic tSync();
        holdClk = 6'h08;
        holdDat = 6'h08;
        rd(base + 20'hC, 32'h00001818);
        rd(base + 20'hC, 32'h00000808);
        holdClk = 6'h00;
        holdDat = 6'h00;
        $display("sync test done");
    endtask
    // Last pair's data half takes masked direction and value writes
    task automatic tData();
        wr(base + 20'h14, 32'h00000F00);
        chk(32'({datPinOe, datPinOut}), 32'h0000083F);
        wr(base + 20'h14, 32'h00000500);
        chk(32'({datPinOe, datPinOut}), 32'h0000001F);
        $display("data test done");
    endtask
    task automatic tUnmapped();
        wr(20'hC5028, 32'h00000F0F);
        chk(32'({datPinOe, clkPinOe}), 32'h00000001);
        rd(20'hC5028, 32'h00000000);
        rd(20'hC5011, 32'h00000000);
        $display("unmapped test done");
    endtask
    // ****************************************************
    // Clock, reset, sequence and watchdog
    // ****************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {regWrite, regRead, holdClk, holdDat} = '0;
        regAddr = 20'h00000;
        regWdata = 32'h00000000;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        tReset();
        tMask();
        tSync();
        tData();
        tUnmapped();
        end_sim();
    end
    // Whole run is about 50 cycles; this is ample margin
    initial begin
        #20000;
        errorCnt++;
        end_sim();
    end
endmodule
